/* src/ppci_pkg.sv */
// Purpose: Shared constants and carriers for the port pin change interrupt block
// Assumes: 8-bit register bus, six port pins
// Notes:   Offsets are word indices on the plain register port
package ppci_pkg;
    localparam int          PPCI_PINS      = 6;
    localparam int          PPCI_DW        = 8;
    localparam int          PPCI_AW        = 3;
    localparam logic [2:0]  ADDR_RISE      = 3'h0;
    localparam logic [2:0]  ADDR_FALL      = 3'h1;
    localparam logic [2:0]  ADDR_FLAGS     = 3'h2;
    localparam logic [2:0]  ADDR_CTRL      = 3'h3;
    localparam logic [2:0]  ADDR_MASK      = 3'h4;
    localparam int          CTRL_MIE_BIT   = 0;
    localparam int          CTRL_SUM_BIT   = 1;
    localparam logic [5:0]  PIN_RESET      = 6'h00;
    localparam logic [7:0]  RD_ZERO        = 8'h00;

    // Register bus request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ppci_req_s;
endpackage

/* src/ppci_top.sv */
// Purpose: Per-pin edge detect with sticky change flags and interrupt/wake
// Assumes: Pins are asynchronous to ref_clk; software uses the plain register port
// Notes:   Flags clear by writing zero; a same-cycle edge always wins
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps

// How it works
// (RULE1) Enabled rising edge sets pin flag
// (RULE2) Enabled falling edge sets pin flag
// (RULE3) Flag sticks until software clears it
// (RULE4) Flag reads zero after reset or clear
// (RULE5) Upper two bits read zero, ignore writes
// (RULE6) Master enable lets pin change wake
// (RULE7) Flag updated before wake is signalled; the code registers flag and wake on the same edge, both from next_flags
// (RULE8) Software clears flags by and-masking
// (RULE9) Detection runs even with master off
// (RULE10) Summary flag is OR of flags
// (RULE11) Edge during clear leaves flag set
// (RULE12) Master enable plus flag raises interrupt; the code raises irq only for flags whose irq_mask bit is clear
// (RULE13) Pins synchronised, edges from sample pairs
module ppci_top (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // Port pins
    input  wire logic [5:0]           port_a_pin,
    // Register port
    input  wire ppci_pkg::ppci_req_s  req,
    output logic [7:0]                rdata,
    // Interrupt and wake
    output logic                      irq,
    output logic                      wake
);
    import ppci_pkg::*;

    // Pin sampling chain
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] prev;

    // Software-visible registers
    logic [5:0] rising_edge_enable;
    logic [5:0] falling_edge_enable;
    logic [5:0] pin_change_flags;
    logic [5:0] irq_mask;
    logic       change_interrupt_master_enable;

    // Combinational helpers
    logic [5:0] hit;
    logic [5:0] next_flags;
    logic [7:0] next_rdata;
    logic       summary;

    // Two-stage synchroniser then one history stage
    // Only sync2 and prev feed logic; sync1 may be metastable and only sync2 reads it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1 <= PIN_RESET;
            sync2 <= PIN_RESET;
            prev  <= PIN_RESET;
        end else begin
            sync1 <= port_a_pin;
            sync2 <= sync1;                                        // RULE13
            prev  <= sync2;                                        // RULE13
        end
    end

    // Edge hits ignore the master enable on purpose
    assign hit = (rising_edge_enable & sync2 & ~prev)              // RULE1 RULE9
               | (falling_edge_enable & ~sync2 & prev);            // RULE2 RULE9

    // Rising enables keep only the six pin bits, so the spare bits read zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rising_edge_enable <= PIN_RESET;
        end else if (req.wr && req.addr == ADDR_RISE) begin
            rising_edge_enable <= req.wdata[5:0];                  // RULE5
        end
    end

    // Falling enables, same layout as the rising ones
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            falling_edge_enable <= PIN_RESET;
        end else if (req.wr && req.addr == ADDR_FALL) begin
            falling_edge_enable <= req.wdata[5:0];                 // RULE5
        end
    end

    // Interrupt mask; a one hides that pin from irq but not from wake
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_mask <= PIN_RESET;
        end else if (req.wr && req.addr == ADDR_MASK) begin
            irq_mask <= req.wdata[5:0];
        end
    end

    // Master enable gates requests only; detection keeps running without it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            change_interrupt_master_enable <= 1'b0;
        end else if (req.wr && req.addr == ADDR_CTRL) begin
            change_interrupt_master_enable <= req.wdata[CTRL_MIE_BIT]; // RULE9
        end
    end

    // Write stores the value given, then hits are ORed on top so a set wins
    // Writing a one also sets a flag, which lets software test the interrupt path
    always_comb begin
        next_flags = pin_change_flags;
        if (req.wr && req.addr == ADDR_FLAGS)
            next_flags = req.wdata[5:0];                           // RULE4 RULE8
        next_flags = next_flags | hit;                             // RULE3 RULE11
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            pin_change_flags <= PIN_RESET;                         // RULE4
        else
            pin_change_flags <= next_flags;                        // RULE3
    end

    assign summary = |pin_change_flags;                            // RULE10

    // Interrupt and wake are registered from next_flags, so they rise on the same edge as the flag
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= change_interrupt_master_enable
                    && |(next_flags & ~irq_mask);                  // RULE12 RULE9
            wake <= change_interrupt_master_enable && |next_flags; // RULE6 RULE7
        end
    end

    // Read mux; unmapped addresses and upper bits read zero
    always_comb begin
        next_rdata = RD_ZERO;
        unique case (req.addr)
            ADDR_RISE:  next_rdata = {2'b00, rising_edge_enable};  // RULE5
            ADDR_FALL:  next_rdata = {2'b00, falling_edge_enable}; // RULE5
            ADDR_FLAGS: next_rdata = {2'b00, pin_change_flags};    // RULE5
            ADDR_MASK:  next_rdata = {2'b00, irq_mask};
            ADDR_CTRL: begin
                next_rdata[CTRL_MIE_BIT] = change_interrupt_master_enable;
                next_rdata[CTRL_SUM_BIT] = summary;                // RULE10
            end
            default:    next_rdata = RD_ZERO;
        endcase
    end

    // Read data stand for one cycle only and are zero otherwise
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            rdata <= RD_ZERO;
        else if (req.rd)
            rdata <= next_rdata;
        else
            rdata <= RD_ZERO;
    end

    // Checks
    a_rise_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rising_edge_enable[0] && sync2[0] && !prev[0]) |=> pin_change_flags[0]) // RULE1
        else $error("rising edge did not set flag");
    a_fall_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (falling_edge_enable[0] && !sync2[0] && prev[0]) |=> pin_change_flags[0]) // RULE2
        else $error("falling edge did not set flag");
    a_flag_sticks: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pin_change_flags[1] && !(req.wr && req.addr == ADDR_FLAGS))
        |=> pin_change_flags[1]) // RULE3
        else $error("flag dropped without clear");
    a_clear_works: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_FLAGS && !req.wdata[2] && !hit[2])
        |=> !pin_change_flags[2]) // RULE4
        else $error("flag not cleared");
    a_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(req.rd) |-> rdata[7:6] == 2'b00) // RULE5
        else $error("upper bits not zero");
    a_wake_on_change: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (change_interrupt_master_enable && hit != PIN_RESET && !(req.wr))
        |=> wake) // RULE6
        else $error("no wake on change");
    a_wake_after_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wake |-> $past(next_flags) != PIN_RESET) // RULE7
        else $error("wake before flag");
    a_no_irq_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(change_interrupt_master_enable) |-> !irq) // RULE9
        else $error("irq with master off");
    a_edge_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_FLAGS && hit[3]) |=> pin_change_flags[3]) // RULE11
        else $error("edge lost during clear");
    a_irq_raised: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (change_interrupt_master_enable && (pin_change_flags & ~irq_mask) != PIN_RESET
         && !req.wr) |=> irq) // RULE12
        else $error("irq not raised");
    a_sum_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_CTRL) |=> rdata[CTRL_SUM_BIT] == $past(summary)) // RULE10
        else $error("summary wrong");

    // Interrupt stays low while nothing unmasked is pending or arriving
    a_irq_masked_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
        ((pin_change_flags & ~irq_mask) == PIN_RESET && hit == PIN_RESET && !req.wr)
        |=> !irq)
        else $error("irq with nothing pending");

    // Master enable low means no request on the next cycle
    a_irq_master_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE9
        !change_interrupt_master_enable |=> !irq)
        else $error("irq while master enable clear");

    // Wake needs the master enable
    a_wake_master: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        !$past(change_interrupt_master_enable) |-> !wake)
        else $error("wake with master off");

    // A pending flag keeps wake up while enabled
    a_wake_held: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        (change_interrupt_master_enable && pin_change_flags != PIN_RESET && !req.wr)
        |=> wake)
        else $error("wake dropped while flag set");

    // No flag and no edge means no wake
    a_wake_off_empty: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        (pin_change_flags == PIN_RESET && hit == PIN_RESET && !req.wr) |=> !wake)
        else $error("wake without any flag");

    // Read data are zero outside the cycle after a read
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        !$past(req.rd) |-> rdata == RD_ZERO)
        else $error("read data outside read cycle");

    // Rising enable register reads back what it holds
    a_rise_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        (req.rd && req.addr == ADDR_RISE) |=> rdata[5:0] == $past(rising_edge_enable))
        else $error("rising enable read wrong");

    // Falling enable register reads back what it holds
    a_fall_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        (req.rd && req.addr == ADDR_FALL) |=> rdata[5:0] == $past(falling_edge_enable))
        else $error("falling enable read wrong");

    // Flag register reads back the sticky flags
    a_flags_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
        (req.rd && req.addr == ADDR_FLAGS) |=> rdata[5:0] == $past(pin_change_flags))
        else $error("flag read wrong");

    // Unmapped addresses read zero
    a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        (req.rd && req.addr > ADDR_MASK) |=> rdata == RD_ZERO)
        else $error("unmapped read not zero");

    // A rising enable write keeps the low six bits
    a_rise_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        (req.wr && req.addr == ADDR_RISE) |=> rising_edge_enable == $past(req.wdata[5:0]))
        else $error("rising enable write lost");

    // Master enable bit reads back
    a_ctrl_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
        (req.rd && req.addr == ADDR_CTRL)
        |=> rdata[CTRL_MIE_BIT] == $past(change_interrupt_master_enable))
        else $error("master enable read wrong");

    // Per-pin checks, one copy for each pin, so no bit is left unwatched
    for (genvar i = 0; i < PPCI_PINS; i++) begin : g_pin_chk
        // Enabled rising edge lands in the flag
        a_rise_each: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
            (rising_edge_enable[i] && sync2[i] && !prev[i]) |=> pin_change_flags[i])
            else $error("rising edge missed on a pin");

        // Enabled falling edge lands in the flag
        a_fall_each: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
            (falling_edge_enable[i] && !sync2[i] && prev[i]) |=> pin_change_flags[i])
            else $error("falling edge missed on a pin");

        // Rising edge with its enable clear is ignored
        a_rise_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
            (!rising_edge_enable[i] && sync2[i] && !prev[i]) |-> !hit[i])
            else $error("disabled rising edge detected");

        // Falling edge with its enable clear is ignored
        a_fall_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
            (!falling_edge_enable[i] && !sync2[i] && prev[i]) |-> !hit[i])
            else $error("disabled falling edge detected");

        // Flag holds until a flag write
        a_stick_each: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
            (pin_change_flags[i] && !(req.wr && req.addr == ADDR_FLAGS))
            |=> pin_change_flags[i])
            else $error("flag dropped on a pin");

        // Writing zero clears when no edge arrives
        a_clear_each: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
            (req.wr && req.addr == ADDR_FLAGS && !req.wdata[i] && !hit[i])
            |=> !pin_change_flags[i])
            else $error("flag not cleared on a pin");

        // Edge during a clear wins
        a_win_each: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE11
            (req.wr && req.addr == ADDR_FLAGS && hit[i]) |=> pin_change_flags[i])
            else $error("edge lost during clear on a pin");

        // No change between samples gives no detection
        a_quiet_each: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE13
            (sync2[i] == prev[i]) |-> !hit[i])
            else $error("detection without a change");
    end
endmodule

/* sim/ppci_pins.sv */
// Purpose: Far-side model of the six port pins
// Assumes: Push-pull source on every pin, no pull resistor
// Notes:   Settle delay keeps edges off the clock grid
`timescale 1ns/1ps
module ppci_pins #(
    parameter int SETTLE_NS = 7
) (
    // Requested levels
    input  wire logic [5:0] pin_tgt,
    // Pin wires
    output logic [5:0]      port_a_pin
);
    // Late slew so edges land mid-cycle, as an unrelated source would
    initial port_a_pin = 6'h00;
    always @(pin_tgt) port_a_pin <= #(SETTLE_NS) pin_tgt;
endmodule

/* sim/ppci_tb_top.sv */
// Purpose: Self-checking bench for the pin change interrupt block
// Assumes: Register port and pin timing as handed over by the designer
// Notes:   Scenarios run in order and share register state
`timescale 1ns/1ps
module ppci_tb_top;
    import ppci_pkg::*;
    logic       ref_clk   = 1'b0;
    logic       rst_n     = 1'b0;
    logic [5:0] pin_tgt   = 6'h00;
    logic [5:0] port_a_pin;
    ppci_req_s  req       = '0;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    int         error_cnt = 0;
    int         n_checks  = 0;
    int         cycles    = 0;
    // 50 MHz system clock
    always #10 ref_clk = ~ref_clk;
    ppci_pins u_ppci_pins (.pin_tgt(pin_tgt), .port_a_pin(port_a_pin));
    ppci_top u_ppci_top (.ref_clk(ref_clk), .rst_n(rst_n), .port_a_pin(port_a_pin),
                         .req(req), .rdata(rdata), .irq(irq), .wake(wake));
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Idle edge after each write keeps strobes from merging
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req <= '0;
        @(posedge ref_clk);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req <= '0;
        #1 cmp8(rdata, exp);
        @(posedge ref_clk);
    endtask
    task automatic lvl(input logic [1:0] exp);
        repeat (2) @(posedge ref_clk);
        #1 cmp8({6'h00, irq, wake}, {6'h00, exp});
        @(posedge ref_clk);
    endtask
    // Enough edges for the pin synchroniser to settle
    task automatic pins(input logic [5:0] v);
        pin_tgt <= v;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic t_reset();
        for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00);
    endtask
    task automatic t_config();
        wr(ADDR_RISE, 8'hfd);
        rd(ADDR_RISE, 8'h3d);
        wr(ADDR_FALL, 8'hc2);
        rd(ADDR_FALL, 8'h02);
        wr(ADDR_FLAGS, 8'hc0);
        rd(ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_edges();
        pins(6'h03);
        rd(ADDR_FLAGS, 8'h01);
        lvl(2'b00);
        rd(ADDR_CTRL, 8'h02);
        pins(6'h00);
        rd(ADDR_FLAGS, 8'h03);
    endtask
    task automatic t_master();
        wr(ADDR_CTRL, 8'h01);
        lvl(2'b11);
        wr(ADDR_MASK, 8'h3f);
        lvl(2'b01);
        wr(ADDR_MASK, 8'h00);
    endtask
    // Read, invert, and-back with 03: the write is 00, so every flag without an edge is cleared
    task automatic t_clear();
        rd(ADDR_FLAGS, 8'h03);
        wr(ADDR_FLAGS, (8'h03 ^ 8'hff) & 8'h03);
        rd(ADDR_FLAGS, 8'h00);
        lvl(2'b00);
        rd(ADDR_CTRL, 8'h01);
    endtask
    // Edge reaches the detector in the very cycle a clearing write is taken
    task automatic t_race();
        pin_tgt <= 6'h01;
        repeat (2) @(posedge ref_clk);
        req <= '{addr: ADDR_FLAGS, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req <= '0;
        @(posedge ref_clk);
        rd(ADDR_FLAGS, 8'h01);
        lvl(2'b11);
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Whole run needs under a hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_config();
        t_edges();
        t_master();
        t_clear();
        t_race();
        results();
    end
endmodule
